/* File: hw/sfq_sequencer.sv */
// sfq_sequencer: serial flash command decode, dual/quad reads, program and erase
// assumes pins are asynchronous to clk_sys; link clock slower than clk_sys/4
`timescale 1ns/10ps
module sfq_sequencer
  import sfq_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYC,
  parameter int SECT_CYCLES = SECT_CYC,
  parameter int BLK_CYCLES = BLK_CYC
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic cs_n_pin,
  input wire logic sclk_pin,
  input wire logic [3:0] dq_i,
  output logic [3:0] dq_o,
  output logic [3:0] dq_oe,
  input wire logic [3:0] block_protect_bits,
  input wire logic [ADDR_W-1:0] prot_lo,
  input wire logic [ADDR_W-1:0] prot_hi,
  output logic write_in_progress_flag,
  output logic write_enable_latch,
  output logic quad_enhanced_mode,
  output logic mem_rd_req,
  output logic [ADDR_W-1:0] mem_rd_addr,
  input wire logic [7:0] mem_rd_data,
  output logic mem_wr_req,
  output logic [ADDR_W-1:0] mem_wr_addr,
  output logic [7:0] mem_wr_data,
  output logic mem_erase_req,
  output logic mem_erase_block,
  output logic [ADDR_W-1:0] mem_erase_addr
);
  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic [1:0] cs_sync_reg, clk_sync_reg;
  logic [3:0] dq_sync1_reg, dq_sync2_reg;
  logic clk_d_reg, cs_d_reg;
  logic rise, fall, cs_rise, cs_low;
  sfq_state_e st_reg;
  logic [7:0] op_reg, sh_reg, mode_reg;
  logic [5:0] cnt_reg;
  logic [2:0] bitc_reg;
  logic [1:0] lanes_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [7:0] out_reg;
  logic [7:0] page_mem [0:PAGE_BYTES-1];
  logic [PAGE_BYTES-1:0] page_vld_reg;
  logic [7:0] wr_idx_reg;
  logic prog_ok_reg, erase_ok_reg;
  sfq_job_e job_reg;
  logic [31:0] tmr_reg;
  logic [8:0] flush_reg;
  sfq_dq_s dq_reg;
  sfq_erase_s er_reg;
  logic enh_reg, enh_keep_reg;
  logic [ADDR_W-1:0] cmd_addr_reg;

  function automatic logic in_prot(input logic [ADDR_W-1:0] a, input logic [3:0] bp,
                                   input logic [ADDR_W-1:0] lo, input logic [ADDR_W-1:0] hi);
    return (bp != 4'h0) && (a >= lo) && (a <= hi);
  endfunction : in_prot

  // last address clock for the active lane width
  function automatic logic addr_done(input logic [1:0] ln, input logic [5:0] c);
    return (ln == 2'h1 && c == DUAL_ADDR_CLKS - 6'h01) ||
           (ln == 2'h2 && c == QUAD_ADDR_CLKS - 6'h01) ||
           (ln == 2'h0 && c == SER_ADDR_CLKS - 6'h01);
  endfunction : addr_done

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) rst_sync_reg <= SYNC_RST;
    else rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cs_sync_reg <= 2'h3;
      clk_sync_reg <= 2'h0;
      dq_sync1_reg <= 4'h0;
      dq_sync2_reg <= 4'h0;
      clk_d_reg <= 1'b0;
      cs_d_reg <= 1'b1;
    end else begin
      cs_sync_reg <= {cs_sync_reg[0], cs_n_pin};
      clk_sync_reg <= {clk_sync_reg[0], sclk_pin};
      dq_sync1_reg <= dq_i;
      dq_sync2_reg <= dq_sync1_reg;
      clk_d_reg <= clk_sync_reg[1];
      cs_d_reg <= cs_sync_reg[1];
    end
  end
  assign cs_low = !cs_sync_reg[1];
  assign rise = cs_low && clk_sync_reg[1] && !clk_d_reg;
  assign fall = cs_low && !clk_sync_reg[1] && clk_d_reg;
  assign cs_rise = cs_sync_reg[1] && !cs_d_reg;

  // shift in on rising edges, lanes_reg selects 1, 2 or 4 bits per clock
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= SFQ_IDLE;
      op_reg <= 8'h00;
      sh_reg <= 8'h00;
      mode_reg <= 8'h00;
      cnt_reg <= 6'h00;
      bitc_reg <= 3'h0;
      lanes_reg <= 2'h0;
      addr_reg <= '0;
      cmd_addr_reg <= '0;
      enh_keep_reg <= 1'b0;
    end else if (cs_rise || !cs_low) begin
      if (!enh_reg) st_reg <= SFQ_OPCODE;
      else st_reg <= write_in_progress_flag ? SFQ_IGNORE : SFQ_ADDR;
      op_reg <= enh_reg ? OP_QUAD_IO : 8'h00;
      lanes_reg <= enh_reg ? 2'h2 : 2'h0;
      cnt_reg <= 6'h00;
      bitc_reg <= 3'h0;
    end else if (rise) begin
      case (st_reg)
        SFQ_OPCODE: begin
          sh_reg <= {sh_reg[6:0], dq_sync2_reg[0]};
          bitc_reg <= bitc_reg + 3'h1;
          if (bitc_reg == 3'h7) begin
            op_reg <= {sh_reg[6:0], dq_sync2_reg[0]};
            cnt_reg <= 6'h00;
            case ({sh_reg[6:0], dq_sync2_reg[0]})
              OP_DUAL_IO: begin
                st_reg <= write_in_progress_flag ? SFQ_IGNORE : SFQ_ADDR;
                lanes_reg <= 2'h1;
              end
              OP_QUAD_IO: begin
                st_reg <= write_in_progress_flag ? SFQ_IGNORE : SFQ_ADDR;
                lanes_reg <= 2'h2;
              end
              OP_PROG, OP_SECT, OP_BLK: begin
                st_reg <= write_in_progress_flag ? SFQ_IGNORE : SFQ_EADDR;
                lanes_reg <= 2'h0;
              end
              default: st_reg <= SFQ_IGNORE;
            endcase
          end
        end
        SFQ_ADDR, SFQ_EADDR: begin
          cnt_reg <= cnt_reg + 6'h01;
          case (lanes_reg)
            2'h1: addr_reg <= {addr_reg[ADDR_W-3:0], dq_sync2_reg[1:0]};
            2'h2: addr_reg <= {addr_reg[ADDR_W-5:0], dq_sync2_reg};
            default: addr_reg <= {addr_reg[ADDR_W-2:0], dq_sync2_reg[0]};
          endcase
          if (addr_done(lanes_reg, cnt_reg)) begin
            cnt_reg <= 6'h00;
            bitc_reg <= 3'h0;
            if (st_reg == SFQ_EADDR) begin
              st_reg <= (op_reg == OP_PROG) ? SFQ_PDATA : SFQ_DATA;
              cmd_addr_reg <= {addr_reg[ADDR_W-2:0], dq_sync2_reg[0]};
            end else if (lanes_reg == 2'h1) st_reg <= SFQ_DUMMY;
            else st_reg <= enh_reg ? SFQ_MODE : SFQ_MODE;
          end
        end
        SFQ_MODE: begin
          // quad: mode byte over two clocks; a toggling mode byte keeps enhanced, dummy length is the same for both
          mode_reg <= {mode_reg[3:0], dq_sync2_reg};
          cnt_reg <= cnt_reg + 6'h01;
          if (cnt_reg == QUAD_MODE_CLKS - 6'h01) begin
            st_reg <= SFQ_DUMMY;
            cnt_reg <= 6'h00;
            enh_keep_reg <= mode_toggles({mode_reg[3:0], dq_sync2_reg});
          end
        end
        SFQ_DUMMY: begin
          cnt_reg <= cnt_reg + 6'h01;
          if ((lanes_reg == 2'h1 && cnt_reg == DUAL_WAIT_CLKS - 6'h01) ||
              (lanes_reg == 2'h2 && cnt_reg == QUAD_ENH_DUMMY_CLKS - 6'h01)) begin
            st_reg <= SFQ_DATA;
            bitc_reg <= 3'h0;
          end
        end
        SFQ_PDATA: begin
          sh_reg <= {sh_reg[6:0], dq_sync2_reg[0]};
          bitc_reg <= bitc_reg + 3'h1;
        end
        SFQ_DATA: begin
          bitc_reg <= bitc_reg + 3'h1; // erase: any clock after address spoils it
        end
        default: st_reg <= st_reg;
      endcase
    end
  end
  // quad plain: 2 mode clocks + 4 dummy clocks = 6 dummy clocks
  // share the same counting with the mode byte ignored unless toggling

  // read data path: fetch byte, shift on falling edges, advance address
  logic rd_active;
  assign rd_active = (st_reg == SFQ_DATA) && (op_reg == OP_DUAL_IO || op_reg == OP_QUAD_IO);
  logic [1:0] slot_reg;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      out_reg <= 8'h00;
      slot_reg <= 2'h0;
      mem_rd_req <= 1'b0;
      mem_rd_addr <= '0;
      dq_reg <= '0;
    end else begin
      mem_rd_req <= 1'b0;
      if (!rd_active) begin
        slot_reg <= 2'h0;
        mem_rd_addr <= addr_reg;
        dq_reg.oe <= 4'h0;
        if (st_reg == SFQ_DUMMY) mem_rd_req <= 1'b1;
      end else if (fall) begin
        if (slot_reg == 2'h0) begin
          out_reg <= mem_rd_data;
          mem_rd_addr <= mem_rd_addr + 24'h000001;
          mem_rd_req <= 1'b1;
        end
        if (lanes_reg == 2'h1) begin
          dq_reg.oe <= 4'h3;
          dq_reg.o <= {2'b00, (slot_reg == 2'h0) ? mem_rd_data[7:6] : out_reg[7-2*slot_reg -: 2]};
          slot_reg <= slot_reg + 2'h1;
        end else begin
          dq_reg.oe <= 4'hF;
          dq_reg.o <= (slot_reg == 2'h0) ? mem_rd_data[7:4] : out_reg[3:0];
          slot_reg <= (slot_reg == 2'h0) ? 2'h1 : 2'h0;
        end
      end
    end
  end
  assign dq_o = dq_reg.o;
  assign dq_oe = dq_reg.oe;

  // enhanced mode state: decided at chip select rise
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) enh_reg <= 1'b0;
    else if (cs_rise && op_reg == OP_QUAD_IO &&
             (st_reg == SFQ_DATA || st_reg == SFQ_DUMMY)) enh_reg <= enh_keep_reg;
  end
  assign quad_enhanced_mode = enh_reg;

  // program page buffer; index wraps in page, later bytes overwrite earlier
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      page_vld_reg <= '0;
      wr_idx_reg <= 8'h00;
    end else if (st_reg == SFQ_EADDR) begin
      page_vld_reg <= '0;
      wr_idx_reg <= {addr_reg[6:0], dq_sync2_reg[0]};
    end else if (rise && st_reg == SFQ_PDATA && bitc_reg == 3'h7) begin
      page_mem[wr_idx_reg] <= {sh_reg[6:0], dq_sync2_reg[0]};
      page_vld_reg[wr_idx_reg] <= 1'b1;
      wr_idx_reg <= wr_idx_reg + 8'h01;
    end
  end

  // frame shape: program ends on a byte boundary, erase ends right after the address
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prog_ok_reg <= 1'b0;
      erase_ok_reg <= 1'b0;
    end else if (!cs_low) begin
      prog_ok_reg <= 1'b0;
      erase_ok_reg <= 1'b0;
    end else if (rise) begin
      prog_ok_reg <= (st_reg == SFQ_PDATA) && (bitc_reg == 3'h7);
      erase_ok_reg <= (st_reg == SFQ_EADDR) && (op_reg == OP_SECT || op_reg == OP_BLK) &&
                      addr_done(lanes_reg, cnt_reg);
    end
  end

  // latch, busy flag, self-timed cycles and memory writeback
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      write_enable_latch <= 1'b0;
      write_in_progress_flag <= 1'b0;
      job_reg <= SFQ_OP_NONE;
      tmr_reg <= 32'h0;
      flush_reg <= 9'h000;
      mem_wr_req <= 1'b0;
      mem_wr_addr <= '0;
      mem_wr_data <= 8'h00;
      er_reg <= '0;
    end else begin
      mem_wr_req <= 1'b0;
      er_reg.req <= 1'b0;
      if (cs_rise && !write_in_progress_flag) begin
        if (st_reg == SFQ_IGNORE && op_reg == OP_WRITE_ENABLE_COMMAND && bitc_reg == 3'h0)
          write_enable_latch <= 1'b1;
        if (prog_ok_reg &&
            write_enable_latch && !in_prot(cmd_addr_reg, block_protect_bits, prot_lo, prot_hi)) begin
          job_reg <= SFQ_OP_PROG;
          write_in_progress_flag <= 1'b1;
          tmr_reg <= 32'(PROG_CYCLES);
          flush_reg <= 9'h000;
        end
        if (erase_ok_reg &&
            write_enable_latch && !in_prot(cmd_addr_reg, block_protect_bits, prot_lo, prot_hi)) begin
          job_reg <= SFQ_OP_ERASE;
          write_in_progress_flag <= 1'b1;
          tmr_reg <= (op_reg == OP_BLK) ? 32'(BLK_CYCLES) : 32'(SECT_CYCLES);
          er_reg.req <= 1'b1;
          er_reg.is_block <= (op_reg == OP_BLK);
          er_reg.addr <= cmd_addr_reg;
        end
      end else if (write_in_progress_flag) begin
        if (job_reg == SFQ_OP_PROG && !flush_reg[8]) begin
          mem_wr_req <= page_vld_reg[flush_reg[7:0]];
          mem_wr_addr <= {cmd_addr_reg[ADDR_W-1:8], flush_reg[7:0]};
          mem_wr_data <= page_mem[flush_reg[7:0]];
          flush_reg <= flush_reg + 9'h001;
        end
        if (tmr_reg > 32'h1) tmr_reg <= tmr_reg - 32'h1;
        else begin
          write_in_progress_flag <= 1'b0;
          write_enable_latch <= 1'b0;
          job_reg <= SFQ_OP_NONE;
        end
      end
    end
  end
  assign mem_erase_req = er_reg.req;
  assign mem_erase_block = er_reg.is_block;
  assign mem_erase_addr = er_reg.addr;
endmodule : sfq_sequencer

/* File: pkg/sfq_pkg.sv */
// sfq_pkg: constants, states and carriers for the serial flash command sequencer
// assumes a single system clock that oversamples the serial link clock
// Notes on behaviour
// - dual read address arrives two bits per clock
// - address on rising edge, data on falling
// - read address increments per byte, wraps zero
// - quad read uses four lines, six dummies
// - enhanced mode byte, four dummies, opcode skipped
// - toggling mode byte keeps mode, else leave
// - quad read rejected while write cycle busy
// - program and erase need write enable latch
// - program data wraps inside the page
// - over 256 bytes keeps the final ones
// - short program touches only sent addresses
// - program needs chip select on byte boundary
// - program self-timed, busy flag, latch cleared
// - protected page program is not executed
// - sector erase sets addressed sector to ones
// - block erase sets addressed block to ones
// - erase needs select rise after address
// - chip select held low whole command
// - erase self-timed, busy flag, status readable
// - protected region erase is not executed
// - any read rejected while cycle busy
package sfq_pkg;
  localparam int CLK_MHZ = 125;
  localparam int ADDR_W = 24;
  localparam logic [7:0] OP_WRITE_ENABLE_COMMAND = 8'h06;
  localparam logic [7:0] OP_DUAL_IO = 8'hBB;
  localparam logic [7:0] OP_QUAD_IO = 8'hEB;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_SECT = 8'h20;
  localparam logic [7:0] OP_BLK = 8'hD8;
  localparam logic [5:0] DUAL_ADDR_CLKS = 6'h0C;
  localparam logic [5:0] DUAL_WAIT_CLKS = 6'h04;
  localparam logic [5:0] QUAD_ADDR_CLKS = 6'h06;
  localparam logic [5:0] QUAD_DUMMY_CLKS = 6'h06;
  localparam logic [5:0] QUAD_MODE_CLKS = 6'h02;
  localparam logic [5:0] QUAD_ENH_DUMMY_CLKS = 6'h04;
  localparam logic [5:0] SER_ADDR_CLKS = 6'h18;
  localparam int PAGE_BYTES = 256;
  localparam int T_PROG_US = 1300;
  localparam int T_SECT_US = 60000;
  localparam int T_BLK_US = 300000;
  localparam int PROG_CYC = T_PROG_US * CLK_MHZ;
  localparam int SECT_CYC = T_SECT_US * CLK_MHZ;
  localparam int BLK_CYC = T_BLK_US * CLK_MHZ;
  localparam logic [1:0] SYNC_RST = 2'h0;

  typedef enum logic [8:0] {
    SFQ_OPCODE = 9'h001,
    SFQ_ADDR = 9'h002,
    SFQ_MODE = 9'h004,
    SFQ_DUMMY = 9'h008,
    SFQ_DATA = 9'h010,
    SFQ_PDATA = 9'h020,
    SFQ_EADDR = 9'h040,
    SFQ_IGNORE = 9'h080,
    SFQ_IDLE = 9'h100
  } sfq_state_e;

  typedef enum logic [2:0] {
    SFQ_OP_NONE = 3'h1,
    SFQ_OP_PROG = 3'h2,
    SFQ_OP_ERASE = 3'h4
  } sfq_job_e;

  typedef struct packed {
    logic [3:0] o;
    logic [3:0] oe;
  } sfq_dq_s;

  typedef struct packed {
    logic req;
    logic is_block;
    logic [ADDR_W-1:0] addr;
  } sfq_erase_s;

  function automatic logic mode_toggles(input logic [7:0] m);
    return m[7:4] == ~m[3:0];
  endfunction : mode_toggles
endpackage : sfq_pkg

/* File: sim/sfq_host.sv */
// sfq_host: host link model driving select, link clock and DQ lines
// assumes 8 ns clk_sys; link clock 80 ns, low between frames
`timescale 1ns/10ps
module sfq_host (
  input wire logic clk_sys,
  input wire logic [3:0] dq_o,
  input wire logic [3:0] dq_oe,
  output logic cs_n_pin,
  output logic sclk_pin,
  output logic [3:0] dq_i
);
  logic [3:0] h_dq = 4'h0;
  logic [3:0] h_en = 4'h0;
  logic flip_reg = 1'b0;
  initial cs_n_pin = 1'b1;
  initial sclk_pin = 1'b0;
  always_ff @(posedge clk_sys) flip_reg <= ~flip_reg;
  // released lines show a changing pattern
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      dq_i[i] = dq_oe[i] ? dq_o[i] : h_en[i] ? h_dq[i] : flip_reg ^ i[0];
    end
  end
  // one link clock; data held through the rising edge
  task automatic tick(input logic [3:0] v, input logic [3:0] en, output logic [3:0] r);
    h_dq = v;
    h_en = en;
    repeat (5) @(posedge clk_sys);
    #1 sclk_pin = 1'b1;
    repeat (5) @(posedge clk_sys);
    #1 r = dq_i;
    sclk_pin = 1'b0;
  endtask : tick
  // n clocks of w bits, most significant first
  task automatic par(input logic [23:0] v, input int w, input int n);
    logic [3:0] m;
    logic [3:0] r;
    m = 4'((1 << w) - 1);
    for (int k = n - 1; k >= 0; k--) begin
      tick(4'(v >> (k * w)) & m, m, r);
    end
  endtask : par
  task automatic rdb(input int w, output logic [7:0] b);
    logic [3:0] r;
    b = 8'h00;
    for (int k = 0; k < 8 / w; k++) begin
      tick(4'h0, 4'h0, r);
      b = (b << w) | 8'(r & 4'((1 << w) - 1));
    end
  endtask : rdb
  task automatic sel();
    cs_n_pin = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 h_en = 4'h0;
  endtask : sel
  task automatic desel();
    h_en = 4'h0;
    repeat (3) @(posedge clk_sys);
    #1 cs_n_pin = 1'b1;
    repeat (12) @(posedge clk_sys);
    #1 h_en = 4'h0;
  endtask : desel
endmodule : sfq_host

/* File: sim/sfq_sequencer_sva.sv */
// sfq_sequencer_sva: port checks for the flash command sequencer
// assumes protect inputs stay steady around each command
`timescale 1ns/10ps
module sfq_sequencer_sva
  import sfq_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYC,
  parameter int SECT_CYCLES = SECT_CYC,
  parameter int BLK_CYCLES = BLK_CYC
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic cs_n_pin,
  input wire logic [3:0] dq_oe,
  input wire logic [3:0] block_protect_bits,
  input wire logic [ADDR_W-1:0] prot_lo,
  input wire logic [ADDR_W-1:0] prot_hi,
  input wire logic write_in_progress_flag,
  input wire logic write_enable_latch,
  input wire logic mem_rd_req,
  input wire logic mem_wr_req,
  input wire logic [ADDR_W-1:0] mem_wr_addr,
  input wire logic mem_erase_req,
  input wire logic [ADDR_W-1:0] mem_erase_addr
);
  localparam int MAX_BUSY = PROG_CYCLES + SECT_CYCLES + BLK_CYCLES;
  int busy_cnt_reg;
  logic [15:0] page_reg;
  logic page_v_reg;
  // busy length and page of the running program
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      busy_cnt_reg <= 0;
    end else begin
      busy_cnt_reg <= write_in_progress_flag ? busy_cnt_reg + 1 : 0;
    end
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      page_reg <= 16'h0000;
      page_v_reg <= 1'b0;
    end else if (mem_wr_req) begin
      page_reg <= mem_wr_addr[23:8];
      page_v_reg <= 1'b1;
    end else if (!write_in_progress_flag) begin
      page_v_reg <= 1'b0;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence s_job_start;
    $rose(write_in_progress_flag);
  endsequence
  sequence s_busy_hold;
    write_in_progress_flag [*8];
  endsequence
  a_busy_hold: assert property (s_job_start |-> s_busy_hold)
    else $error("busy flag too short");
  a_latch_first: assert property (s_job_start |-> $past(write_enable_latch))
    else $error("job started without latch");
  a_latch_drop: assert property ($fell(write_in_progress_flag) |-> !write_enable_latch)
    else $error("latch still set at cycle end");
  a_busy_bound: assert property (busy_cnt_reg <= MAX_BUSY)
    else $error("busy flag stuck");
  a_wr_busy: assert property (mem_wr_req |-> write_in_progress_flag)
    else $error("write outside cycle");
  a_erase_busy: assert property (mem_erase_req |-> ##[0:2] write_in_progress_flag)
    else $error("erase without busy flag");
  a_erase_unprot: assert property (mem_erase_req && block_protect_bits != 4'h0 |->
    mem_erase_addr < prot_lo || mem_erase_addr > prot_hi) else $error("protected erase");
  a_rd_refused: assert property (write_in_progress_flag |-> !mem_rd_req)
    else $error("read while busy");
  a_oe_busy: assert property (write_in_progress_flag |-> dq_oe == 4'h0)
    else $error("drive while busy");
  a_oe_idle: assert property (cs_n_pin [*8] |-> dq_oe == 4'h0)
    else $error("drive while deselected");
  a_wr_page: assert property (mem_wr_req && page_v_reg |-> mem_wr_addr[23:8] == page_reg)
    else $error("program left its page");
endmodule : sfq_sequencer_sva

/* File: sim/sfq_sequencer_tb.sv */
// sfq_sequencer_tb: self-checking bench for the flash command sequencer
// assumes sfq_host on the link and a pattern standing in for the array
`timescale 1ns/10ps
module sfq_sequencer_tb
  import sfq_pkg::*;
;
  localparam int PCYC = 400;
  localparam int ECYC = 3000;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic cs_n_pin, sclk_pin, write_in_progress_flag, write_enable_latch, quad_enhanced_mode;
  logic mem_rd_req, mem_wr_req, mem_erase_req, mem_erase_block;
  logic [3:0] dq_i, dq_o, dq_oe;
  logic [3:0] block_protect_bits = 4'h1;
  logic [23:0] prot_lo = 24'h100000;
  logic [23:0] prot_hi = 24'h1FFFFF;
  logic [23:0] mem_rd_addr, mem_wr_addr, mem_erase_addr;
  logic [7:0] mem_rd_data, mem_wr_data;
  logic [31:0] wq[$];
  int fails = 0;
  int tests_run = 0;
  int rd_cnt = 0;
  int er_cnt = 0;
  logic [7:0] eop [5] = '{OP_SECT, OP_SECT, OP_BLK, OP_BLK, OP_SECT};
  logic [23:0] ead [5] = '{24'h123456, 24'h000ABC, 24'h234567, 24'h1F0000, 24'h000ABC};
  logic [7:0] mds [8] = '{8'hA5, 8'hFF, 8'h5A, 8'h00, 8'hF0, 8'hAA, 8'h0F, 8'h55};
  always #4 clk_sys = ~clk_sys;
  sfq_sequencer #(.PROG_CYCLES(PCYC), .SECT_CYCLES(ECYC), .BLK_CYCLES(ECYC)) i_sfq_sequencer (
    .clk_sys, .reset_n, .cs_n_pin, .sclk_pin, .dq_i, .dq_o, .dq_oe, .block_protect_bits,
    .prot_lo, .prot_hi, .write_in_progress_flag, .write_enable_latch, .quad_enhanced_mode,
    .mem_rd_req, .mem_rd_addr, .mem_rd_data, .mem_wr_req, .mem_wr_addr, .mem_wr_data,
    .mem_erase_req, .mem_erase_block, .mem_erase_addr);
  sfq_host h (.clk_sys, .dq_o, .dq_oe, .cs_n_pin, .sclk_pin, .dq_i);
  function automatic logic [7:0] mem_val(input logic [23:0] a);
    return ~a[7:0] ^ a[15:8];
  endfunction : mem_val
  function automatic logic [7:0] pdat(input int i);
    return 8'(i) ^ {i[8], 7'h00};
  endfunction : pdat
  assign mem_rd_data = mem_val(mem_rd_addr);
  always @(posedge clk_sys) begin
    if (mem_wr_req === 1'b1) wq.push_back({mem_wr_addr, mem_wr_data});
    if (mem_rd_req === 1'b1) rd_cnt++;
    if (mem_erase_req === 1'b1) er_cnt++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %0h expected %0h", $time, m, got, exp);
    end
  endtask : chk
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test
  task automatic wait_idle();
    int k;
    for (k = 0; k < 6000 && write_in_progress_flag !== 1'b0; k++) begin
      @(posedge clk_sys);
      #1;
    end
    chk(32'(k < 6000), 32'h1, "cycle never ended");
    if (k >= 6000) finish_test();
  endtask : wait_idle
  task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int n, input int extra);
    h.sel();
    h.par(24'(op), 1, 8);
    h.par(a, 1, 24);
    for (int i = 0; i < n; i++) h.par(24'(pdat(i)), 1, 8);
    if (extra > 0) h.par(24'h0000A5, 1, extra);
    h.desel();
  endtask : cmd
  task automatic write_enable_command();
    h.sel();
    h.par(24'(OP_WRITE_ENABLE_COMMAND), 1, 8);
    h.desel();
  endtask : write_enable_command
  task automatic check_prog(input logic [23:0] a, input int n);
    logic [7:0] e;
    chk(32'(wq.size()), 32'(n > 256 ? 256 : n), "byte count");
    foreach (wq[j]) begin
      for (int i = 0; i < n; i++) if (8'(a + 24'(i)) == wq[j][15:8]) e = pdat(i);
      chk({16'h0, wq[j][31:16]}, {16'h0, a[23:8]}, "page");
      chk(32'(wq[j][7:0]), 32'(e), "programmed data");
    end
    wq.delete();
  endtask : check_prog
  task automatic rd(input logic [7:0] op, input logic [23:0] a, input logic [7:0] md,
                    input int w, input int n);
    logic [7:0] b;
    h.sel();
    if (op != 8'h00) h.par(24'(op), 1, 8);
    h.par(a, w, 24 / w);
    h.par(24'(md), w, 8 / w);
    if (w == 4) h.par(24'h0, 0, 4);
    for (int i = 0; i < n; i++) begin
      h.rdb(w, b);
      chk(32'(b), 32'(mem_val(a + 24'(i))), "read data");
    end
    h.desel();
  endtask : rd
  initial begin
    int n0;
    repeat (6) @(posedge clk_sys);
    #1 reset_n = 1'b1;
    repeat (8) @(posedge clk_sys);
    #1 cmd(OP_PROG, 24'h000010, 1, 0);
    chk(32'(wq.size()) + 32'(write_in_progress_flag), 32'h0, "program without latch");
    write_enable_command();
    chk(32'(write_enable_latch), 32'h1, "latch set");
    cmd(OP_PROG, 24'h0000FE, 3, 3);
    chk(32'(wq.size()) + 32'(write_in_progress_flag), 32'h0, "ragged program");
    write_enable_command();
    cmd(OP_PROG, 24'h0000FE, 3, 0);
    chk(32'(write_in_progress_flag), 32'h1, "program busy");
    wait_idle();
    chk(32'(write_enable_latch), 32'h0, "latch after program");
    check_prog(24'h0000FE, 3);
    write_enable_command();
    cmd(OP_PROG, 24'h100040, 2, 0);
    chk(32'(wq.size()) + 32'(write_in_progress_flag), 32'h0, "protected program");
    write_enable_command();
    cmd(OP_PROG, 24'h004520, 258, 0);
    wait_idle();
    check_prog(24'h004520, 258);
    for (int t = 0; t < 5; t++) begin
      write_enable_command();
      n0 = er_cnt;
      cmd(eop[t], ead[t], t == 4 ? 1 : 0, 0);
      chk(32'(er_cnt - n0), 32'(t == 1 || t == 2), "erase count");
      if (t == 1 || t == 2) begin
        chk(32'(mem_erase_block), 32'(t == 2), "erase kind");
        chk(32'(mem_erase_addr >> (t * 4 + 8)), 32'(ead[t] >> (t * 4 + 8)), "region");
        rd(t == 1 ? OP_DUAL_IO : OP_QUAD_IO, 24'h0, 8'h0, t * 2, 0);
        chk(32'(rd_cnt), 32'h0, "read while busy");
        wait_idle();
        chk(32'(write_enable_latch), 32'h0, "latch after erase");
      end
    end
    rd(OP_DUAL_IO, 24'hFFFFFE, 8'h00, 2, 3);
    for (int k = 0; k < 8; k++) begin
      rd(k % 2 == 0 ? OP_QUAD_IO : 8'h00, 24'h00ABC0 + 24'(k), mds[k], 4, 2);
      chk(32'(quad_enhanced_mode), 32'(k % 2 == 0), "enhanced mode");
    end
    finish_test();
  end
endmodule : sfq_sequencer_tb
bind sfq_sequencer sfq_sequencer_sva #(.PROG_CYCLES(PROG_CYCLES), .SECT_CYCLES(SECT_CYCLES),
  .BLK_CYCLES(BLK_CYCLES)) i_sfq_sequencer_sva (.clk_sys, .reset_n, .cs_n_pin, .dq_oe,
  .block_protect_bits, .prot_lo, .prot_hi, .write_in_progress_flag, .write_enable_latch,
  .mem_rd_req, .mem_wr_req, .mem_wr_addr, .mem_erase_req, .mem_erase_addr);
